/* File: rtl/civ_pkg.sv */
// Constants and types for the core interrupt vectoring block
// Notes on behaviour
// - Finish current instruction, then redirect to vector
// - Uncleared arithmetic exception stays pending, refires
// - Core priorities fixed; peripheral routing fixed, line i to number 11+i
// - Vector offset equals four times number
// - Emulator zero highest at 0x00; reset at 0x04
// - Illegal or misaligned access is number 2
// - Stack overflow or full is number 3
// - Core timer uses number 4 or 32
// - 5 serial error, 6 breakpoint, 7 reserved
// - 8-10 external lines, 11-29 peripheral
// - 30 and 31 are circular buffer wraps
// - 33-36 are the arithmetic exceptions
// - 37 is the low-priority emulator request
// - 38-41 software requests; 41 lowest
// - 17-24 and 28-29 sit in second latch
package civ_pkg;
    localparam int          CIV_NUM_IRQ      = 42;
    localparam int          CIV_NUM_IDX_W    = 6;
    localparam int          CIV_VEC_W        = 8;
    localparam int          CIV_VEC_STEP     = 4;
    localparam int          CIV_EXT_LO_A     = 17;
    localparam int          CIV_EXT_HI_A     = 24;
    localparam int          CIV_EXT_LO_B     = 28;
    localparam int          CIV_EXT_HI_B     = 29;
    localparam int          CIV_IRQ_EMU_HI   = 0;
    localparam int          CIV_IRQ_RESET    = 1;
    localparam int          CIV_IRQ_ILLEGAL  = 2;
    localparam int          CIV_IRQ_STACK    = 3;
    localparam int          CIV_IRQ_TMR_HI   = 4;
    localparam int          CIV_IRQ_SPERR    = 5;
    localparam int          CIV_IRQ_BKPT     = 6;
    localparam int          CIV_IRQ_RSVD     = 7;
    localparam int          CIV_IRQ_EXT_LINE = 8;
    localparam int          CIV_IRQ_PERIPH   = 11;
    localparam int          CIV_NUM_PERIPH   = 19;
    localparam int          CIV_IRQ_CB_A     = 30;
    localparam int          CIV_IRQ_CB_B     = 31;
    localparam int          CIV_IRQ_TMR_LO   = 32;
    localparam int          CIV_IRQ_ARITH    = 33;
    localparam int          CIV_NUM_ARITH    = 4;
    localparam int          CIV_IRQ_EMU_LO   = 37;
    localparam int          CIV_IRQ_SOFT     = 38;
    localparam int          CIV_NUM_SOFT     = 4;
    localparam logic [41:0] CIV_LATCH_RST    = 42'h000_0000_0000;
    localparam logic [41:0] CIV_MASK_RST     = 42'h000_0000_0003;

    typedef enum logic [1:0] {CIV_IDLE, CIV_WAIT_DONE, CIV_SERVICE} civ_state_t;

    typedef struct packed {
        civ_state_t                 state;
        logic [CIV_NUM_IRQ-1:0]     latch;
        logic [CIV_NUM_IRQ-1:0]     in_service;
        logic [CIV_NUM_IDX_W-1:0]   cur_num;
        logic                       take;
        logic [CIV_VEC_W-1:0]       vec;
        logic [CIV_NUM_IDX_W-1:0]   num;
        logic                       busy;
        logic [CIV_NUM_IRQ-1:0]     latch_main;
        logic [CIV_NUM_IRQ-1:0]     latch_ext;
    } civ_regs_t;
endpackage

/* File: rtl/civ_core_irq_vectoring.sv */
// Core interrupt latch, fixed-priority selection and vector generation
`timescale 1ns/10ps
module civ_core_irq_vectoring
    import civ_pkg::*;
(
    input  wire logic                      CLK_SYS,
    input  wire logic                      ARST_N,
    input  wire logic                      EMU_HIGH_IRQ,
    input  wire logic                      RESET_IRQ,
    input  wire logic                      ILLEGAL_IOP_ACCESS,
    input  wire logic                      MISALIGNED_LONG_ACCESS,
    input  wire logic                      STATUS_STACK_OVF,
    input  wire logic                      MODE_STACK_OVF,
    input  wire logic                      PC_STACK_FULL,
    input  wire logic                      CORE_TIMER_ZERO,
    input  wire logic                      TIMER_LOW_PRIO_SEL,
    input  wire logic                      SERIAL_PORT_ERR_IRQ,
    input  wire logic                      SPERR_PRESENT,
    input  wire logic                      HW_BREAKPOINT_IRQ,
    input  wire logic [2:0]                EXT_LINE_IRQ,
    input  wire logic [CIV_NUM_PERIPH-1:0] PERIPH_IRQ,
    input  wire logic                      CIRCBUF_A_WRAP_IRQ,
    input  wire logic                      CIRCBUF_B_WRAP_IRQ,
    input  wire logic [CIV_NUM_ARITH-1:0]  ARITH_STATUS,
    input  wire logic                      EMU_LOW_IRQ,
    input  wire logic [CIV_NUM_SOFT-1:0]   SOFT_IRQ_SET,
    input  wire logic [CIV_NUM_IRQ-1:0]    IRQ_MASK_REG,
    input  wire logic                      GLOBAL_IRQ_EN,
    input  wire logic                      INSTR_DONE,
    input  wire logic                      RETURN_FROM_IRQ,
    output logic                           IRQ_TAKE,
    output logic [CIV_VEC_W-1:0]           IRQ_VECTOR,
    output logic [CIV_NUM_IDX_W-1:0]       IRQ_NUMBER,
    output logic                           IRQ_BUSY,
    output logic [CIV_NUM_IRQ-1:0]         IRQ_LATCH_MAIN,
    output logic [CIV_NUM_IRQ-1:0]         IRQ_LATCH_EXT
);
    logic       rst_s1_ff;
    logic       rst_s2_ff;
    civ_regs_t  cur_ff;
    civ_regs_t  nxt_cur;
    logic [CIV_NUM_IRQ-1:0] raw_req;
    logic [CIV_NUM_IRQ-1:0] ext_sel;
    logic [CIV_NUM_IRQ-1:0] elig;
    logic                   any_elig;
    logic [CIV_NUM_IDX_W-1:0] win_num;

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // Source wiring into fixed slots
    always_comb
    begin
        raw_req                  = '0;
        raw_req[CIV_IRQ_EMU_HI]  = EMU_HIGH_IRQ;
        raw_req[CIV_IRQ_RESET]   = RESET_IRQ;
        raw_req[CIV_IRQ_ILLEGAL] = ILLEGAL_IOP_ACCESS | MISALIGNED_LONG_ACCESS;
        raw_req[CIV_IRQ_STACK]   = STATUS_STACK_OVF | MODE_STACK_OVF | PC_STACK_FULL;
        raw_req[CIV_IRQ_TMR_HI]  = CORE_TIMER_ZERO & ~TIMER_LOW_PRIO_SEL;
        raw_req[CIV_IRQ_TMR_LO]  = CORE_TIMER_ZERO & TIMER_LOW_PRIO_SEL;
        raw_req[CIV_IRQ_SPERR]   = SERIAL_PORT_ERR_IRQ & SPERR_PRESENT;
        raw_req[CIV_IRQ_BKPT]    = HW_BREAKPOINT_IRQ;
        raw_req[CIV_IRQ_RSVD]    = 1'b0;
        for (int i = 0; i < 3; i++)
            raw_req[CIV_IRQ_EXT_LINE + i] = EXT_LINE_IRQ[2 - i];
        for (int i = 0; i < CIV_NUM_PERIPH; i++)
            raw_req[CIV_IRQ_PERIPH + i] = PERIPH_IRQ[i];
        raw_req[CIV_IRQ_CB_A]    = CIRCBUF_A_WRAP_IRQ;
        raw_req[CIV_IRQ_CB_B]    = CIRCBUF_B_WRAP_IRQ;
        for (int i = 0; i < CIV_NUM_ARITH; i++)
            raw_req[CIV_IRQ_ARITH + i] = ARITH_STATUS[i];
        raw_req[CIV_IRQ_EMU_LO]  = EMU_LOW_IRQ;
        for (int i = 0; i < CIV_NUM_SOFT; i++)
            raw_req[CIV_IRQ_SOFT + i] = SOFT_IRQ_SET[i];
    end

    // Latch bank split
    genvar g;
    generate
        for (g = 0; g < CIV_NUM_IRQ; g++)
        begin : gen_bank
            assign ext_sel[g] = ((g >= CIV_EXT_LO_A) && (g <= CIV_EXT_HI_A)) ||
                                ((g >= CIV_EXT_LO_B) && (g <= CIV_EXT_HI_B));
        end
    endgenerate

    assign elig = cur_ff.latch & IRQ_MASK_REG & ~cur_ff.in_service;

    // Fixed priority: lowest number wins
    always_comb
    begin
        any_elig = 1'b0;
        win_num  = '0;
        for (int i = CIV_NUM_IRQ - 1; i >= 0; i--)
        begin
            if (elig[i])
            begin
                any_elig = 1'b1;
                win_num  = CIV_NUM_IDX_W'(i);
            end
        end
    end

    always_comb
    begin
        nxt_cur       = cur_ff;
        nxt_cur.take  = 1'b0;
        unique case (cur_ff.state)
            CIV_IDLE:
            begin
                if (any_elig && GLOBAL_IRQ_EN)
                begin
                    nxt_cur.cur_num = win_num;
                    nxt_cur.state   = CIV_WAIT_DONE;
                end
            end
            CIV_WAIT_DONE:
            begin
                if (INSTR_DONE)
                begin
                    nxt_cur.take                       = 1'b1;
                    nxt_cur.num                        = cur_ff.cur_num;
                    nxt_cur.vec                        = CIV_VEC_W'(cur_ff.cur_num * CIV_VEC_STEP);
                    nxt_cur.in_service[cur_ff.cur_num] = 1'b1;
                    nxt_cur.latch[cur_ff.cur_num]      = 1'b0;
                    nxt_cur.busy                       = 1'b1;
                    nxt_cur.state                      = CIV_SERVICE;
                end
            end
            CIV_SERVICE:
            begin
                if (RETURN_FROM_IRQ)
                begin
                    nxt_cur.in_service[cur_ff.num] = 1'b0;
                    nxt_cur.busy                   = 1'b0;
                    nxt_cur.state                  = CIV_IDLE;
                end
            end
            default:
                nxt_cur.state = CIV_IDLE;
        endcase
        // Arrivals set the latch; a set beats the acknowledge clear
        nxt_cur.latch = nxt_cur.latch | raw_req;
        // Bank copies registered so the outputs come straight from flops
        nxt_cur.latch_main = nxt_cur.latch & ~ext_sel;
        nxt_cur.latch_ext  = nxt_cur.latch & ext_sel;
    end

    always_ff @(posedge CLK_SYS or negedge rst_s2_ff)
    begin
        if (!rst_s2_ff)
        begin
            cur_ff <= '{state: CIV_IDLE, latch: CIV_LATCH_RST, in_service: '0,
                        cur_num: '0, take: 1'b0, vec: '0, num: '0, busy: 1'b0,
                        latch_main: CIV_LATCH_RST, latch_ext: CIV_LATCH_RST};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign IRQ_TAKE       = cur_ff.take;
    assign IRQ_VECTOR     = cur_ff.vec;
    assign IRQ_NUMBER     = cur_ff.num;
    assign IRQ_BUSY       = cur_ff.busy;
    assign IRQ_LATCH_MAIN = cur_ff.latch_main;
    assign IRQ_LATCH_EXT  = cur_ff.latch_ext;

    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_s2_ff);

    chk_vector_times_four: assert property (IRQ_TAKE |-> IRQ_VECTOR == CIV_VEC_W'(IRQ_NUMBER * 4))
        else $error("vector is not four times number");
    chk_take_after_done: assert property (IRQ_TAKE |-> $past(INSTR_DONE))
        else $error("redirect before instruction done");
    chk_emu_first: assert property ((cur_ff.state == CIV_IDLE && elig[0] && GLOBAL_IRQ_EN)
        |=> cur_ff.cur_num == 6'h00)
        else $error("emulator request not chosen first");
    chk_priority_pick: assert property ((cur_ff.state == CIV_IDLE && any_elig && GLOBAL_IRQ_EN)
        |=> (cur_ff.cur_num == $past(win_num)) && ((($past(elig)) & ((42'h1 << cur_ff.cur_num) - 42'h1)) == '0))
        else $error("lower number pending but not chosen");
    chk_arith_refire: assert property ((ARITH_STATUS[0]) |=> cur_ff.latch[CIV_IRQ_ARITH] || IRQ_TAKE)
        else $error("uncleared exception lost");
    chk_bank_split: assert property ((IRQ_LATCH_EXT & ~ext_sel) == '0 && ext_sel[17] && ext_sel[29] && !ext_sel[25])
        else $error("latch bank split wrong");
    chk_reserved_quiet: assert property (!cur_ff.latch[CIV_IRQ_RSVD])
        else $error("reserved slot latched");
    chk_timer_slot: assert property ((CORE_TIMER_ZERO && TIMER_LOW_PRIO_SEL) |=> cur_ff.latch[CIV_IRQ_TMR_LO])
        else $error("low timer option not latched");
    chk_soft_slot: assert property (SOFT_IRQ_SET[3] |=> cur_ff.latch[41] || IRQ_TAKE)
        else $error("software request lost");
    chk_return_idle: assert property ((cur_ff.state == CIV_SERVICE && RETURN_FROM_IRQ) |=> !IRQ_BUSY)
        else $error("return did not end service");

    // Redirect strobe and service window
    chk_take_single: assert property (IRQ_TAKE |=> !IRQ_TAKE)
        else $error("take strobe longer than one cycle");

    chk_take_busy: assert property (IRQ_TAKE |-> IRQ_BUSY)
        else $error("take without service window");

    chk_no_nesting: assert property (IRQ_TAKE |-> !$past(IRQ_BUSY))
        else $error("take while already in service");

    chk_wait_boundary: assert property ((cur_ff.state == CIV_WAIT_DONE && !INSTR_DONE) |=> !IRQ_TAKE)
        else $error("redirect without instruction boundary");

    chk_service_mark: assert property (IRQ_BUSY |-> cur_ff.in_service[IRQ_NUMBER])
        else $error("in-service mark missing");

    chk_service_clear: assert property (!IRQ_BUSY |-> cur_ff.in_service == '0)
        else $error("in-service mark left after return");

    chk_vector_hold: assert property (!IRQ_TAKE |-> $stable(IRQ_VECTOR) && $stable(IRQ_NUMBER))
        else $error("vector changed without take");

    chk_vector_range: assert property (IRQ_TAKE |-> IRQ_VECTOR <= 8'hA4)
        else $error("vector beyond last table entry");

    chk_reserved_untaken: assert property (IRQ_TAKE |-> IRQ_NUMBER != 6'h07)
        else $error("reserved slot taken");

    chk_gie_hold: assert property ((cur_ff.state == CIV_IDLE && !GLOBAL_IRQ_EN) |=> cur_ff.state == CIV_IDLE)
        else $error("selection while globally disabled");

    // Source to slot mapping
    chk_reset_slot: assert property (RESET_IRQ |=> cur_ff.latch[CIV_IRQ_RESET])
        else $error("reset request not in its slot");

    chk_access_slot: assert property (MISALIGNED_LONG_ACCESS |=> cur_ff.latch[CIV_IRQ_ILLEGAL])
        else $error("misaligned access not in its slot");

    chk_stack_slot: assert property (PC_STACK_FULL |=> cur_ff.latch[CIV_IRQ_STACK])
        else $error("stack full not in its slot");

    chk_timer_high: assert property ((CORE_TIMER_ZERO && !TIMER_LOW_PRIO_SEL) |=> cur_ff.latch[CIV_IRQ_TMR_HI])
        else $error("high timer option not latched");

    chk_sperr_absent: assert property ((!SPERR_PRESENT && !cur_ff.latch[CIV_IRQ_SPERR]) |=> !cur_ff.latch[CIV_IRQ_SPERR])
        else $error("absent serial error source latched");

    chk_ext_line_zero: assert property (EXT_LINE_IRQ[0] |=> cur_ff.latch[10])
        else $error("external line zero not in its slot");

    chk_circbuf_b: assert property (CIRCBUF_B_WRAP_IRQ |=> cur_ff.latch[CIV_IRQ_CB_B])
        else $error("second buffer wrap not in its slot");

    chk_arith_last: assert property (ARITH_STATUS[3] |=> cur_ff.latch[36])
        else $error("invalid exception not in its slot");

    chk_emu_low_slot: assert property (EMU_LOW_IRQ |=> cur_ff.latch[CIV_IRQ_EMU_LO])
        else $error("low emulator request not in its slot");

    chk_split_regs: assert property (((IRQ_LATCH_MAIN | IRQ_LATCH_EXT) == cur_ff.latch) &&
        ((IRQ_LATCH_MAIN & IRQ_LATCH_EXT) == '0))
        else $error("bank copies disagree with latch");

    // Every slot keeps its own request
    generate
        for (g = 0; g < CIV_NUM_IRQ; g++)
        begin : gen_slot_chk
            chk_slot_latch: assert property (raw_req[g] |=> cur_ff.latch[g])
                else $error("request not latched in its slot");
        end
    endgenerate

    cov_take_emu: cover property (IRQ_TAKE && IRQ_NUMBER == 6'h00);
    cov_take_arith: cover property (IRQ_TAKE && IRQ_NUMBER == 6'h21);
    cov_take_lowest: cover property (IRQ_TAKE && IRQ_NUMBER == 6'h29);
    cov_nested_wait: cover property (cur_ff.state == CIV_WAIT_DONE ##1 cur_ff.state == CIV_WAIT_DONE ##1 IRQ_TAKE);
    cov_arith_refire: cover property ((IRQ_TAKE && IRQ_NUMBER == 6'h22) ##[1:40] (IRQ_TAKE && IRQ_NUMBER == 6'h22));
endmodule

/* File: tb/civ_seq_model.sv */
// Program sequencer model: instruction boundaries and handler returns
`timescale 1ns/10ps
module civ_seq_model
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] done_gap,
    input  wire logic       irq_busy,
    output logic            instr_done,
    output logic            ret_irq
);
    logic [3:0] gap_ff;
    logic [4:0] svc_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_ff     <= 4'h0;
            svc_ff     <= 5'h00;
            instr_done <= 1'b0;
            ret_irq    <= 1'b0;
        end
        else
        begin
            // Boundary every cycle or every few cycles
            gap_ff     <= (gap_ff >= done_gap) ? 4'h0 : gap_ff + 4'h1;
            instr_done <= (gap_ff == 4'h0);
            // Handler ends by return alone
            svc_ff     <= irq_busy ? ((svc_ff == 5'h1F) ? svc_ff : svc_ff + 5'h01) : 5'h00;
            ret_irq    <= irq_busy && (svc_ff == 5'h06);
        end
    end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the core interrupt vectoring block
`timescale 1ns/10ps
module testbench;
    import civ_pkg::*;
    localparam logic [41:0] EXT_BITS = 42'h000_31FE_0000;
    logic clk_sys = 1'b0, arst_n = 1'b0, gie = 1'b0, sperr_pres = 1'b1, done_q = 1'b0;
    logic [41:0] src = '0, mask = '1;
    logic [2:0] alt = '0;
    logic [3:0] gap = 4'h0;
    logic instr_done, ret_irq, irq_take, irq_busy;
    logic [7:0] irq_vector;
    logic [5:0] irq_number;
    logic [41:0] latch_main, latch_ext;
    int n_errors = 0, checks = 0, cyc = 0;

    civ_core_irq_vectoring u_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .EMU_HIGH_IRQ(src[0]), .RESET_IRQ(src[1]),
        .ILLEGAL_IOP_ACCESS(src[2]), .MISALIGNED_LONG_ACCESS(alt[0]), .STATUS_STACK_OVF(src[3]),
        .MODE_STACK_OVF(alt[1]), .PC_STACK_FULL(alt[2]), .CORE_TIMER_ZERO(src[4] | src[32]),
        .TIMER_LOW_PRIO_SEL(src[32]), .SERIAL_PORT_ERR_IRQ(src[5]), .SPERR_PRESENT(sperr_pres),
        .HW_BREAKPOINT_IRQ(src[6]), .EXT_LINE_IRQ({src[8], src[9], src[10]}), .PERIPH_IRQ(src[29:11]),
        .CIRCBUF_A_WRAP_IRQ(src[30]), .CIRCBUF_B_WRAP_IRQ(src[31]), .ARITH_STATUS(src[36:33]),
        .EMU_LOW_IRQ(src[37]), .SOFT_IRQ_SET(src[41:38]), .IRQ_MASK_REG(mask), .GLOBAL_IRQ_EN(gie),
        .INSTR_DONE(instr_done), .RETURN_FROM_IRQ(ret_irq), .IRQ_TAKE(irq_take), .IRQ_VECTOR(irq_vector),
        .IRQ_NUMBER(irq_number), .IRQ_BUSY(irq_busy), .IRQ_LATCH_MAIN(latch_main), .IRQ_LATCH_EXT(latch_ext));

    civ_seq_model u_seq (.clk(clk_sys), .rst_n(arst_n), .done_gap(gap), .irq_busy(irq_busy),
        .instr_done(instr_done), .ret_irq(ret_irq));

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        done_q <= instr_done;
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic expect_take(input int n);
        int w;
        w = 0;
        @(posedge clk_sys);
        #2;
        while (irq_take !== 1'b1 && w < 80)
        begin
            @(posedge clk_sys);
            #2;
            w++;
        end
        check("take", 42'(irq_take), 42'h1);
        check("number", 42'(irq_number), 42'(n));
        check("vector", 42'(irq_vector), 42'(CIV_VEC_STEP * n));
        check("after boundary", 42'(done_q), 42'h1);
    endtask

    task automatic wait_idle();
        int w;
        w = 0;
        while (irq_busy !== 1'b0 && w < 80)
        begin
            @(posedge clk_sys);
            #2;
            w++;
        end
        check("busy", 42'(irq_busy), 42'h0);
    endtask

    task automatic pulse(input logic [41:0] v);
        @(posedge clk_sys);
        #5;
        src = v;
        @(posedge clk_sys);
        #5;
        src = '0;
    endtask

    // Every source alone, with the latch split
    task automatic t_each();
        gap = 4'h0;
        gie = 1'b1;
        for (int n = 0; n < CIV_NUM_IRQ; n++)
        begin
            if (n == CIV_IRQ_RSVD)
                continue;
            pulse(42'h1 << n);
            check("latch ext", latch_ext, (42'h1 << n) & EXT_BITS);
            check("latch main", latch_main, (42'h1 << n) & ~EXT_BITS);
            expect_take(n);
            wait_idle();
        end
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_sys);
            #5;
            alt = 3'h1 << i;
            @(posedge clk_sys);
            #5;
            alt = 3'h0;
            expect_take((i == 0) ? CIV_IRQ_ILLEGAL : CIV_IRQ_STACK);
            wait_idle();
        end
    endtask

    // All but the low timer slot pending at once, one masked, one absent variant source
    task automatic t_prio();
        gap = 4'h5;
        gie = 1'b0;
        sperr_pres = 1'b0;
        mask = ~42'h1;
        pulse(42'h3FE_FFFF_FF7F);
        gie = 1'b1;
        for (int n = 1; n < CIV_NUM_IRQ; n++)
        begin
            if (n == CIV_IRQ_RSVD || n == CIV_IRQ_SPERR || n == CIV_IRQ_TMR_LO)
                continue;
            expect_take(n);
            wait_idle();
        end
        #3;
        mask = '1;
        expect_take(CIV_IRQ_EMU_HI);
        wait_idle();
        sperr_pres = 1'b1;
        gap = 4'h0;
    endtask

    // Status left set refires; cleared before return it is taken once more from the latch, then settles
    task automatic t_arith();
        @(posedge clk_sys);
        #5;
        src = 42'h1 << 34;
        expect_take(34);
        wait_idle();
        expect_take(34);
        #3;
        src = '0;
        repeat (60) @(posedge clk_sys);
        #2;
        check("arith latch", latch_main & (42'h1 << 34), 42'h0);
        check("idle", 42'(irq_busy), 42'h0);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk_sys);
        #5;
        arst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        t_each();
        t_prio();
        t_arith();
        finish_test();
    end
endmodule
